// file: hdl/touch_scan_unit.sv
// Capacitive touch key scan unit: APB registers, manual and auto scan, charge counting.
// Assumes the pad logic returns one comparator trip pulse per charge threshold crossing.
// Functional notes
// - Only manual mode or auto-scan mode is active, never both.
// - Hardware clears the start bit when a manual conversion ends.
// - Done flag low while converting, high at end; count then valid.
// - Overflow flag set when the count passes 10 bits, else zero.
// - 3-bit time field scales conversion length; reset value 100.
// - Channel codes 0-13 pick keys, 14 undefined, 15 reference capacitor.
// - Auto-scan covers keys 0 to 3 only.
// - Auto scans every 2048 or 4096 slow clock cycles by rate bit.
// - Auto count below threshold raises touch flag and wakes processor.
// - Manual end sets flag; write DFh or start bit clears it.
// - Auto touch sets flag; service entry or DFh write clears it.
// - Power-down bit: 0 runs, 1 powers down; resets to 1. Here auto-scan runs only with the bit at 1 and stops at 0.
// - Count bits 9-8 in data register low bits, 7-0 in low register.
// - Start bit auto-clear unreliable at very slow system clock.
// - Channel-count field picks keys 0, 0-1, 0-2 or 0-3.
// - Each auto key has an 11-bit threshold, high and low registers.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ns
`include "touch_scan_defs.svh"
module touch_scan_unit #(
  parameter int SLOW_DIV    = `TS_SLOW_DIV,
  parameter int BASE_PERIOD = `TS_BASE_PERIOD,
  parameter int RATE_SLOW   = 4096,
  parameter int RATE_FAST   = 2048
) (
  // Clock, reset, enable
  input  wire logic                    i_clk_sys,
  input  wire logic                    i_srst,
  input  wire logic                    i_clk_en,
  // APB slave
  input  wire logic                    i_psel,
  input  wire logic                    i_penable,
  input  wire logic                    i_pwrite,
  input  wire logic [11:0]             i_paddr,
  input  wire logic [31:0]             i_pwdata,
  output logic      [31:0]             o_prdata,
  output logic                         o_pready,
  output logic                         o_pslverr,
  // Sense front end
  input  wire logic                    i_charge_trip,
  output logic      [3:0]              o_sense_channel,
  output logic                         o_charge_enable,
  output logic      [2:0]              o_conversion_time_select,
  // Processor side
  input  wire logic                    i_isr_entry,
  output logic                         o_touch_interrupt_flag,
  output logic                         o_wake
);
  import touch_scan_pkg::*;

  // At least one settle cycle even with a slow clock
  localparam int EOC_DLY = (`TS_EOC_DELAY_CYC < 1) ? 1 : `TS_EOC_DELAY_CYC;

  logic [7:0]  control_reg;
  logic [7:0]  channel_select_reg;
  logic [7:0]  auto_ctrl_reg;
  logic [7:0]  thr_high10_reg;
  logic [7:0]  thr_high32_reg;
  logic [7:0]  thr_low_reg [4];
  logic        start_reg;
  logic        done_reg;
  logic        ovf_reg;
  logic        flag_reg;
  logic [3:0]  touched_reg;
  count_t      count_reg;
  logic [10:0] charge_reg;
  logic [15:0] period_reg;
  logic [5:0]  slow_div_reg;
  logic [12:0] slow_tick_reg;
  logic [1:0]  auto_key_reg;
  logic        auto_busy_reg;
  logic [15:0] delay_reg;
  scan_state_t state_reg;
  logic [31:0] prdata_reg;
  logic [3:0]  sense_channel_reg;

  logic        wr;
  logic        rd_ok;
  logic [9:0]  word_idx;
  logic        auto_mode;
  logic        powered_down;
  logic        sw_start;
  logic        auto_due;
  logic        conv_end;
  logic [15:0] limit;
  logic [10:0] thr_sel;
  logic        flag_set;
  logic        flag_clr;
  logic [31:0] rdata_next;
  logic [10:0] charge_next;

  assign word_idx = i_paddr[11:2];
  assign wr       = i_clk_en && i_psel && i_penable && i_pwrite;
  // Zero wait: every access completes in its first access cycle
  assign o_pready = 1'b1;

  assign auto_mode    = auto_ctrl_reg[3];
  assign powered_down = control_reg[`TS_PD_BIT];
  assign sw_start     = wr && (word_idx == 10'(`TS_IDX_START)) && i_pwdata[`TS_START_BIT];

  assign limit = 16'(BASE_PERIOD << control_reg[2:0]);

  always_comb begin
    rd_ok = 1'b1;
    rdata_next = 32'h0000_0000;
    unique case (word_idx)
      10'(`TS_IDX_FLAGS):     rdata_next[`TS_FLAG_BIT] = flag_reg;
      10'(`TS_IDX_DATA):      rdata_next[3:0] = {done_reg, ovf_reg, count_reg[9:8]};
      10'(`TS_IDX_CNT_LOW):   rdata_next[7:0] = count_reg[7:0];
      10'(`TS_IDX_CONTROL):   rdata_next[7:0] = control_reg;
      10'(`TS_IDX_CHANNEL_SELECT):     rdata_next[7:0] = channel_select_reg;
      10'(`TS_IDX_AUTO_CTRL): rdata_next[7:0] = {touched_reg, auto_ctrl_reg[3:0]};
      10'(`TS_IDX_THR_H10):   rdata_next[7:0] = thr_high10_reg;
      10'(`TS_IDX_THR_H32):   rdata_next[7:0] = thr_high32_reg;
      10'(`TS_IDX_START):     rdata_next[`TS_START_BIT] = start_reg;
      default: begin
        if (word_idx >= 10'(`TS_IDX_THR_L0) && word_idx < 10'(`TS_IDX_THR_L0 + 4)) begin
          rdata_next[7:0] = thr_low_reg[2'(word_idx - 10'(`TS_IDX_THR_L0))];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end
  assign o_pslverr = i_psel && i_penable && !rd_ok;

  // Read data caught in the setup cycle, so the zero-wait access sees a flop
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      prdata_reg <= 32'h0000_0000;
    end else if (i_clk_en && i_psel && !i_penable) begin
      prdata_reg <= rdata_next;
    end
  end
  assign o_prdata = prdata_reg;

  // Register writes
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      control_reg        <= `TS_CTRL_RESET;
      channel_select_reg <= `TS_CHANNEL_SELECT_RESET;
      auto_ctrl_reg      <= `TS_AUTO_RESET;
      thr_high10_reg     <= 8'h00;
      thr_high32_reg     <= 8'h00;
      for (int i = 0; i < 4; i++) begin
        thr_low_reg[i] <= `TS_THR_L_RESET;
      end
    end else if (wr) begin
      unique case (word_idx)
        10'(`TS_IDX_CONTROL):   control_reg <= {i_pwdata[7], 4'h0, i_pwdata[2:0]};
        10'(`TS_IDX_CHANNEL_SELECT):     channel_select_reg <= i_pwdata[7:0];
        10'(`TS_IDX_AUTO_CTRL): auto_ctrl_reg <= {4'h0, i_pwdata[3:0]};
        10'(`TS_IDX_THR_H10):   thr_high10_reg <= {1'b0, i_pwdata[6:4], 1'b0, i_pwdata[2:0]};
        10'(`TS_IDX_THR_H32):   thr_high32_reg <= {1'b0, i_pwdata[6:4], 1'b0, i_pwdata[2:0]};
        default: begin
          if (word_idx >= 10'(`TS_IDX_THR_L0) && word_idx < 10'(`TS_IDX_THR_L0 + 4)) begin
            thr_low_reg[2'(word_idx - 10'(`TS_IDX_THR_L0))] <= i_pwdata[7:0];
          end
        end
      endcase
    end
  end

  // slow clock tick and scan interval
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      slow_div_reg  <= 6'h00;
      slow_tick_reg <= 13'h0000;
    end else if (i_clk_en) begin
      // Parked at zero outside auto mode, so the first scan starts promptly
      if (!auto_mode || !powered_down) begin
        slow_div_reg  <= 6'h00;
        slow_tick_reg <= 13'h0000;
      end else if (slow_div_reg == 6'(SLOW_DIV - 1)) begin
        slow_div_reg <= 6'h00;
        if (slow_tick_reg == 13'((auto_ctrl_reg[2] ? RATE_FAST : RATE_SLOW) - 1)) begin
          slow_tick_reg <= 13'h0000;
        end else begin
          slow_tick_reg <= slow_tick_reg + 13'h0001;
        end
      end else begin
        slow_div_reg <= slow_div_reg + 6'h01;
      end
    end
  end
  // auto runs with both bits set
  assign auto_due = auto_mode && powered_down && (slow_div_reg == 6'(SLOW_DIV - 1))
                    && (slow_tick_reg == 13'h0000) && !auto_busy_reg;

  always_comb begin
    unique case (auto_key_reg)
      2'd0: thr_sel = {thr_high10_reg[2:0], thr_low_reg[0]};
      2'd1: thr_sel = {thr_high10_reg[6:4], thr_low_reg[1]};
      2'd2: thr_sel = {thr_high32_reg[2:0], thr_low_reg[2]};
      2'd3: thr_sel = {thr_high32_reg[6:4], thr_low_reg[3]};
    endcase
  end

  assign conv_end = (state_reg == ST_CHARGE) && (period_reg >= limit - 16'h0001);
  // Final cycle's trip counts too, so the result equals the trips seen
  assign charge_next = charge_reg + {10'h000, i_charge_trip && !charge_reg[10]};

  // Conversion sequencer
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      state_reg     <= ST_IDLE;
      start_reg     <= 1'b0;
      done_reg      <= 1'b1;
      ovf_reg       <= 1'b0;
      count_reg     <= 10'h000;
      charge_reg    <= 11'h000;
      period_reg    <= 16'h0000;
      delay_reg     <= 16'h0000;
      auto_key_reg  <= 2'd0;
      auto_busy_reg <= 1'b0;
      touched_reg   <= 4'h0;
    end else if (i_clk_en) begin
      unique case (state_reg)
        ST_IDLE: begin
          if (sw_start && !auto_mode && !powered_down) begin
            start_reg  <= 1'b1;
            done_reg   <= 1'b0;
            ovf_reg    <= 1'b0;
            charge_reg <= 11'h000;
            delay_reg  <= 16'h0000;
            state_reg  <= ST_DELAY;
          end else if (auto_due) begin
            auto_busy_reg <= 1'b1;
            auto_key_reg  <= 2'd0;
            touched_reg   <= 4'h0;
            charge_reg    <= 11'h000;
            delay_reg     <= 16'h0000;
            state_reg     <= ST_DELAY;
          end
        end
        // done falls within the settle delay
        ST_DELAY: begin
          period_reg <= 16'h0000;
          delay_reg  <= delay_reg + 16'h0001;
          if (delay_reg == 16'(EOC_DLY - 1)) begin
            state_reg <= ST_CHARGE;
          end
        end
        ST_CHARGE: begin
          period_reg <= period_reg + 16'h0001;
          charge_reg <= charge_next;
          if (conv_end) begin
            if (auto_busy_reg) begin
              if (charge_next < thr_sel) begin
                touched_reg[auto_key_reg] <= 1'b1;
              end
              if (auto_key_reg == auto_ctrl_reg[1:0]) begin
                auto_busy_reg <= 1'b0;
                state_reg     <= ST_IDLE;
              end else begin
                auto_key_reg <= auto_key_reg + 2'd1;
                charge_reg   <= 11'h000;
                state_reg    <= ST_DELAY;
              end
            end else begin
              start_reg <= 1'b0;
              done_reg  <= 1'b1;
              count_reg <= charge_next[9:0];
              ovf_reg   <= charge_next[10];
              state_reg <= ST_IDLE;
            end
          end
        end
      endcase
      // leaving auto mode abandons a scan and hands the unit back
      if (!auto_mode && (auto_busy_reg || powered_down)) begin
        state_reg     <= ST_IDLE;
        auto_busy_reg <= 1'b0;
      end
      // software may clear a start bit left standing
      if (wr && word_idx == 10'(`TS_IDX_START) && !i_pwdata[`TS_START_BIT]) begin
        start_reg <= 1'b0;
      end
    end
  end

  // Auto sets only on a touch, manual on every end
  assign flag_set = conv_end && (!auto_busy_reg || (charge_next < thr_sel));
  assign flag_clr = (wr && word_idx == 10'(`TS_IDX_FLAGS) && i_pwdata[7:0] == `TS_FLAG_CLEAR_VAL)
                    || (sw_start && !auto_mode) || (i_isr_entry && auto_mode);

  // Set wins over clear
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      flag_reg <= 1'b0;
    end else if (i_clk_en) begin
      if (flag_set) begin
        flag_reg <= 1'b1;
      end else if (flag_clr) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // channel routing, auto uses keys 0-3
  always_ff @(posedge i_clk_sys) begin
    if (i_srst) begin
      sense_channel_reg <= `TS_CH_REFCAP;
    end else if (i_clk_en) begin
      sense_channel_reg <= auto_busy_reg ? {2'b00, auto_key_reg} : channel_select_reg[3:0];
    end
  end
  // One cycle of lag is hidden inside the settle delay
  assign o_sense_channel          = sense_channel_reg;
  // Undefined channel code charges nothing, so its count stays zero
  assign o_charge_enable          = (state_reg == ST_CHARGE)
                                    && (auto_busy_reg || channel_select_reg[3:0] != `TS_CH_UNDEF);
  assign o_conversion_time_select = control_reg[2:0];
  assign o_touch_interrupt_flag   = flag_reg;
  assign o_wake                   = flag_reg && auto_mode;
endmodule

// file: inc/touch_scan_defs.svh
// Register offsets, field positions, reset values and timing counts for the touch scan unit.
// Included by the design; definitions only.
`ifndef TOUCH_SCAN_DEFS_SVH
`define TOUCH_SCAN_DEFS_SVH
`define TS_IDX_FLAGS      8'h95
`define TS_IDX_DATA       8'hAA
`define TS_IDX_CNT_LOW    8'hAC
`define TS_IDX_CONTROL    8'hAD
`define TS_IDX_CHANNEL_SELECT      8'hAE
`define TS_IDX_AUTO_CTRL  8'hAF
`define TS_IDX_THR_H10    8'hC2
`define TS_IDX_THR_H32    8'hC3
`define TS_IDX_THR_L0     8'hC4
`define TS_IDX_START      8'hF8
`define TS_FLAG_BIT       5
`define TS_FLAG_CLEAR_VAL 8'hDF
`define TS_START_BIT      5
`define TS_PD_BIT         7
`define TS_CTRL_RESET     8'h84
`define TS_CHANNEL_SELECT_RESET    8'hFF
`define TS_AUTO_RESET     8'h03
`define TS_THR_L_RESET    8'h40
`define TS_CH_REFCAP      4'hF
`define TS_CH_UNDEF       4'hE
`define TS_CLK_HZ         25000000
`define TS_EOC_DELAY_NS   3000
`define TS_EOC_DELAY_CYC  ((`TS_EOC_DELAY_NS * (`TS_CLK_HZ / 1000000)) / 1000)
`define TS_SLOW_DIV       32
`define TS_BASE_PERIOD    128
`endif

// file: inc/touch_scan_pkg.sv
// Types for the touch scan unit.
// Constants live in touch_scan_defs.svh.
package touch_scan_pkg;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_DELAY,
    ST_CHARGE
  } scan_state_t;
  typedef logic [9:0] count_t;
endpackage

// file: dv/touch_scan_unit_assertions.sv
// Port checker for the touch scan unit.
// Assumes zero-wait APB; BASE_PERIOD comes from the bound instance.
`timescale 1ns/1ns
module touch_scan_unit_assertions #(
  parameter int BASE_PERIOD = 128
) (
  // Clock, reset
  input wire logic        i_clk_sys,
  input wire logic        i_srst,
  // APB
  input wire logic        i_psel,
  input wire logic        i_penable,
  input wire logic        i_pwrite,
  input wire logic [11:0] i_paddr,
  input wire logic [31:0] i_pwdata,
  input wire logic [31:0] o_prdata,
  // Sense and processor side
  input wire logic        i_isr_entry,
  input wire logic        o_charge_enable,
  input wire logic [2:0]  o_conversion_time_select,
  input wire logic        o_touch_interrupt_flag,
  input wire logic        o_wake
);
  logic        acc;
  logic [15:0] chg_cnt;
  assign acc = i_psel && i_penable;
  // One conversion at the longest time select; the count restarts in each settle delay
  always_ff @(posedge i_clk_sys) begin
    if (i_srst || !o_charge_enable) begin
      chg_cnt <= 16'h0000;
    end else begin
      chg_cnt <= chg_cnt + 16'h0001;
    end
  end
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (i_srst);
  a_flag_dfh_clear: assert property (acc && i_pwrite && i_paddr == 12'h254 && i_pwdata[7:0] == 8'hDF
    && !o_charge_enable |=> !o_touch_interrupt_flag) else $error("flag survived clear write");
  a_wake_needs_flag: assert property (o_wake |-> o_touch_interrupt_flag) else $error("wake without flag");
  a_isr_clears_flag: assert property (i_isr_entry && o_wake && !o_charge_enable
    |=> !o_touch_interrupt_flag) else $error("service entry left flag set");
  a_flag_after_charge: assert property ($rose(o_touch_interrupt_flag) |-> $past(o_charge_enable)
    || $past(o_charge_enable, 2) || $past(o_charge_enable, 3)) else $error("flag rose without conversion");
  a_reset_defaults: assert property ($fell(i_srst) |-> !o_touch_interrupt_flag && !o_charge_enable
    && o_conversion_time_select == 3'h4) else $error("wrong state after reset");
  a_time_follows: assert property (acc && i_pwrite && i_paddr == 12'h2B4
    |=> o_conversion_time_select == $past(i_pwdata[2:0])) else $error("time select not written");
  a_charge_bounded: assert property (chg_cnt <= (BASE_PERIOD << 7)) else $error("charge phase too long");
  a_done_low_busy: assert property (acc && !i_pwrite && i_paddr == 12'h2A8 && o_charge_enable
    |-> !o_prdata[3]) else $error("done high while charging");
endmodule
bind touch_scan_unit touch_scan_unit_assertions #(.BASE_PERIOD(BASE_PERIOD)) u_chk (
  .i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_psel(i_psel), .i_penable(i_penable), .i_pwrite(i_pwrite),
  .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_prdata(o_prdata), .i_isr_entry(i_isr_entry),
  .o_charge_enable(o_charge_enable), .o_conversion_time_select(o_conversion_time_select),
  .o_touch_interrupt_flag(o_touch_interrupt_flag), .o_wake(o_wake));

// file: dv/touch_pad_model.sv
// Electrodes and charge capacitor: one trip every i_trip_div+1 charge cycles.
// Assumes the bench slows the trips to mimic a touched key.
`timescale 1ns/1ns
module touch_pad_model (
  // Clock
  input  wire logic       i_clk_sys,
  // Front end
  input  wire logic       i_charge_enable,
  input  wire logic [3:0] i_trip_div,
  output logic            o_charge_trip
);
  logic [3:0] div_reg;
  always_ff @(posedge i_clk_sys) begin
    if (!i_charge_enable || div_reg == i_trip_div) begin
      div_reg <= 4'h0;
    end else begin
      div_reg <= div_reg + 4'h1;
    end
  end
  // scanned pin floats, no trips idle
  assign o_charge_trip = i_charge_enable && div_reg == 4'h0;
endmodule

// file: dv/capacitive_touch_scan_unit_test.sv
// Bench: APB master, manual and auto scans against the pad model.
// Assumes zero-wait APB and a shortened base period.
`timescale 1ns/1ns
module capacitive_touch_scan_unit_test;
  localparam int BP = 16;
  // Byte address is four times the register index
  localparam logic [11:0] adr_flags = 12'h254, adr_data = 12'h2A8, adr_low = 12'h2B0, adr_ctrl = 12'h2B4;
  localparam logic [11:0] adr_channel_select = 12'h2B8, adr_auto = 12'h2BC, adr_start = 12'h3E0;
  logic        clk = 1'b0, srst = 1'b1, psel = 1'b0, pen = 1'b0, pwr = 1'b0, isr = 1'b0;
  logic        pready, se, trip, chen, flag, wake, qe;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, q;
  logic [3:0]  chan, div = 4'h0;
  logic [2:0]  tsel;
  int          errors = 0, checked = 0, cycles = 0;
  touch_scan_unit #(.SLOW_DIV(2), .BASE_PERIOD(BP), .RATE_SLOW(8), .RATE_FAST(4)) dut (.i_clk_sys(clk),
    .i_srst(srst), .i_clk_en(1'b1), .i_psel(psel), .i_penable(pen), .i_pwrite(pwr), .i_paddr(paddr),
    .i_pwdata(pwdata), .o_prdata(prdata), .o_pready(pready), .o_pslverr(se), .i_charge_trip(trip),
    .o_sense_channel(chan), .o_charge_enable(chen), .o_conversion_time_select(tsel), .i_isr_entry(isr),
    .o_touch_interrupt_flag(flag), .o_wake(wake));
  touch_pad_model pad (.i_clk_sys(clk), .i_charge_enable(chen), .i_trip_div(div), .o_charge_trip(trip));
  always #20 clk = ~clk;
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      errors++;
      conclude();
    end
  end
  task conclude;
    $display("errors=%0d checked=%0d", errors, checked);
    if (errors == 0 && checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  task chk(input logic [31:0] s, input logic [31:0] x);
    checked++;
    if (s !== x) begin
      errors++;
      $display("ERROR %0t: saw %h want %h", $time, s, x);
    end
  endtask
  task wt(input int n);
    repeat (n) @(posedge clk);
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge clk);
    psel   <= 1'b1;
    pen    <= 1'b0;
    pwr    <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    q  = prdata;
    qe = se;
    psel <= 1'b0;
    pen  <= 1'b0;
  endtask
  task conv(input logic [2:0] t, input logic [3:0] c, input logic [9:0] cnt, input logic ov);
    int n;
    // power-down cleared, time and channel set, then start
    apb(1'b1, adr_ctrl, {29'h0, t});
    apb(1'b1, adr_channel_select, {28'h000000F, c});
    apb(1'b1, adr_start, 32'h20);
    apb(1'b0, adr_data, 32'h0);
    chk(q[3], 0);
    chk(flag, 0);
    wt(80);
    n = 0;
    do begin apb(1'b0, adr_data, 32'h0); n++; end while (q[3] !== 1'b1 && n < 3000);
    chk(q[2], ov);
    if (!ov) begin
      chk(q[1:0], cnt[9:8]);
      apb(1'b0, adr_low, 32'h0);
      chk(q[7:0], cnt[7:0]);
    end
    apb(1'b0, adr_start, 32'h0);
    chk(q[5], 0);
    chk(flag, 1);
    chk(chan, c);
    chk(tsel, t);
    wt(1260);
  endtask
  task t_reset;
    apb(1'b0, adr_ctrl, 32'h0);
    chk(q[7:0], 8'h84);
    chk(pready, 1);
    apb(1'b0, adr_channel_select, 32'h0);
    chk(q[7:0], 8'hFF);
    apb(1'b0, 12'h010, 32'h0);
    chk(qe, 1);
    chk(q, 32'h0);
    apb(1'b1, adr_low, 32'hFF);
    apb(1'b0, adr_low, 32'h0);
    chk(q[7:0], 8'h00);
  endtask
  task t_manual;
    conv(3'h7, 4'h0, 10'h000, 1'b1);
    conv(3'h0, 4'h3, 10'h010, 1'b0);
    conv(3'h3, 4'hD, 10'h080, 1'b0);
    conv(3'h0, 4'hF, 10'h010, 1'b0);
    apb(1'b1, adr_flags, 32'hDF);
    wt(1);
    chk(flag, 0);
    // Powered down: start must be ignored
    apb(1'b1, adr_ctrl, 32'h80);
    apb(1'b1, adr_start, 32'h20);
    wt(100);
    apb(1'b0, adr_data, 32'h0);
    chk(q[3], 1);
    chk(flag, 0);
  endtask
  task t_auto;
    int n;
    div <= 4'h7;
    // power-down and auto enable both set
    apb(1'b1, adr_ctrl, 32'h84);
    apb(1'b1, adr_auto, 32'h0C);
    // wait for the auto scan to raise the touch flag
    n = 0;
    while (flag !== 1'b1 && n < 20000) begin @(posedge clk); n++; end
    chk(flag, 1);
    chk(wake, 1);
    apb(1'b0, adr_auto, 32'h0);
    chk(q[7:4], 4'h1);
    @(posedge clk) isr <= 1'b1;
    @(posedge clk) isr <= 1'b0;
    @(posedge clk);
    chk(flag, 0);
    apb(1'b1, adr_auto, 32'h03);
    wt(2);
    chk(wake, 0);
    div <= 4'h0;
    wt(400);
    conv(3'h0, 4'h0, 10'h010, 1'b0);
  endtask
  initial begin
    wt(6);
    srst <= 1'b0;
    t_reset();
    t_manual();
    t_auto();
    conclude();
  end
endmodule
